// >>> verilog/fuse_defs.svh
// register offsets, field positions and reset values of the fuse access block
`ifndef FUSE_DEFS_SVH
`define FUSE_DEFS_SVH
`define FUSE_OFS_WDATA     4'h0
`define FUSE_OFS_ADDR      4'h4
`define FUSE_OFS_CTRL_LO   4'h6
`define FUSE_OFS_CTRL_HI   4'h7
`define FUSE_OFS_RDATA     4'h8
`define FUSE_OFS_BOOT      4'hc
`define FUSE_BIT_READ      0
`define FUSE_BIT_READ_ARM  1
`define FUSE_BIT_MODE      3
`define FUSE_BIT_BURN      6
`define FUSE_BOOT_ADDR     11'h400
`define FUSE_RST_WORD      32'h0000_0000
`define FUSE_RST_HALF      16'h0000
`define FUSE_RST_BYTE      8'h00
`endif

// >>> verilog/fuse_pkg.sv
// types shared by the fuse access block
`default_nettype none
package fuse_pkg;
   typedef enum logic [1:0] {
      st_boot,
      st_boot_wait,
      st_idle
   } seq_state_e;
endpackage : fuse_pkg
`default_nettype wire

// >>> verilog/fuse_array.sv
// one-time-programmable word array with weak and strong bit planes
`timescale 1ns/1ps
`default_nettype none
module fuse_array #(
   parameter int ADDR_W = 11,
   parameter int DATA_W = 32
) (
   input  wire logic              clk,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   output logic      [DATA_W-1:0] rd_weak,
   output logic      [DATA_W-1:0] rd_strong
);
   // a bit burned once is weak; a second burn makes it strong
   // blank fuses read zero until burned, never unknown
   logic [DATA_W-1:0] weak_mem   [0:(1<<ADDR_W)-1] = '{default: '0};
   logic [DATA_W-1:0] strong_mem [0:(1<<ADDR_W)-1] = '{default: '0};
   logic [DATA_W-1:0] next_weak;
   logic [DATA_W-1:0] next_strong;

   always_comb begin
      next_weak   = weak_mem[addr] | wdata;
      next_strong = strong_mem[addr] | (wdata & weak_mem[addr]);
   end

   // fuses only ever set, never clear
   always_ff @(posedge clk) begin
      if (wr_en) begin
         weak_mem[addr]   <= next_weak;
         strong_mem[addr] <= next_strong;
      end
      if (rd_en) begin
         rd_weak   <= weak_mem[addr];
         rd_strong <= strong_mem[addr];
      end
   end
endmodule : fuse_array
`default_nettype wire

// >>> verilog/fuse_access.sv
// fuse memory access sequencer behind the byte-wide register port
`timescale 1ns/1ps
`default_nettype none
`include "fuse_defs.svh"
module fuse_access #(
   parameter int ADDR_W = 11
) (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       reg_we,
   input  wire logic       reg_re,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic            prog_mode,
   output logic            boot_done
);
   ////////////////////////////////////////////////////////////////////////
   fuse_pkg::seq_state_e state;
   fuse_pkg::seq_state_e next_state;
   logic [31:0] write_data;
   logic [15:0] word_addr;
   logic [7:0]  ctrl_lo;
   logic [7:0]  ctrl_hi;
   logic [31:0] read_data;
   logic [31:0] boot_word;
   logic        rd_capture;
   logic [31:0] next_write_data;
   logic [15:0] next_word_addr;
   logic [7:0]  next_ctrl_lo;
   logic [7:0]  next_ctrl_hi;
   logic [31:0] next_read_data;
   logic [31:0] next_boot_word;
   logic        next_rd_capture;
   logic        next_prog_mode;
   logic        next_boot_done;
   logic [7:0]  next_reg_rdata;
   logic        lo_wr;
   logic        burn_go;
   logic        read_go;
   logic        mem_rd;
   logic [ADDR_W-1:0] mem_addr;
   logic [31:0] rd_weak;
   logic [31:0] rd_strong;
   logic [31:0] rd_word;

   assign lo_wr = reg_we && (reg_addr == `FUSE_OFS_CTRL_LO);

   assign burn_go = lo_wr && (state == fuse_pkg::st_idle) &&
                    reg_wdata[`FUSE_BIT_BURN] && !ctrl_lo[`FUSE_BIT_BURN];
   // read launch: 0x03 followed by 0x01
   assign read_go = lo_wr && (state == fuse_pkg::st_idle) &&
                    reg_wdata[`FUSE_BIT_READ] && !reg_wdata[`FUSE_BIT_READ_ARM] &&
                    ctrl_lo[`FUSE_BIT_READ_ARM];
   assign mem_rd   = read_go || (state == fuse_pkg::st_boot);
   assign mem_addr = (state == fuse_pkg::st_boot) ? ADDR_W'(`FUSE_BOOT_ADDR) :
                                                    word_addr[ADDR_W-1:0];
   // margin mode only trusts strong bits, so a single burn may verify badly
   assign rd_word  = prog_mode ? rd_strong : (rd_weak | rd_strong);

   fuse_array #(
      .ADDR_W (ADDR_W),
      .DATA_W (32)
   ) u_array (
      .clk       (clk),
      .wr_en     (burn_go),
      .rd_en     (mem_rd),
      .addr      (mem_addr),
      .wdata     (write_data),
      .rd_weak   (rd_weak),
      .rd_strong (rd_strong)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state      = state;
      next_write_data = write_data;
      next_word_addr  = word_addr;
      next_ctrl_lo    = ctrl_lo;
      next_ctrl_hi    = ctrl_hi;
      next_read_data  = read_data;
      next_boot_word  = boot_word;
      next_prog_mode  = prog_mode;
      next_boot_done  = boot_done;
      next_rd_capture = read_go;
      // registers held
      // only a register write changes data or address, never an action
      if (reg_we) begin
         case (reg_addr)
            4'h0: next_write_data[7:0]   = reg_wdata;
            4'h1: next_write_data[15:8]  = reg_wdata;
            4'h2: next_write_data[23:16] = reg_wdata;
            4'h3: next_write_data[31:24] = reg_wdata;
            4'h4: next_word_addr[7:0]    = reg_wdata;
            4'h5: next_word_addr[15:8]   = reg_wdata;
            4'h6: next_ctrl_lo           = reg_wdata;
            4'h7: next_ctrl_hi           = reg_wdata;
            default: ;
         endcase
      end
      if (lo_wr && reg_wdata[`FUSE_BIT_MODE])
         next_prog_mode = 1'b1;
      if (rd_capture)
         next_read_data = rd_word;
      case (state)
         fuse_pkg::st_boot: next_state = fuse_pkg::st_boot_wait;
         fuse_pkg::st_boot_wait: begin
            next_boot_word = rd_weak | rd_strong;
            next_boot_done = 1'b1;
            next_state     = fuse_pkg::st_idle;
         end
         fuse_pkg::st_idle: next_state = fuse_pkg::st_idle;
         default: next_state = fuse_pkg::st_boot;
      endcase
      case (reg_addr)
         4'h0: next_reg_rdata = write_data[7:0];
         4'h1: next_reg_rdata = write_data[15:8];
         4'h2: next_reg_rdata = write_data[23:16];
         4'h3: next_reg_rdata = write_data[31:24];
         4'h4: next_reg_rdata = word_addr[7:0];
         4'h5: next_reg_rdata = word_addr[15:8];
         4'h6: next_reg_rdata = ctrl_lo;
         4'h7: next_reg_rdata = ctrl_hi;
         4'h8: next_reg_rdata = read_data[7:0];
         4'h9: next_reg_rdata = read_data[15:8];
         4'ha: next_reg_rdata = read_data[23:16];
         4'hb: next_reg_rdata = read_data[31:24];
         4'hc: next_reg_rdata = boot_word[7:0];
         4'hd: next_reg_rdata = boot_word[15:8];
         4'he: next_reg_rdata = boot_word[23:16];
         default: next_reg_rdata = boot_word[31:24];
      endcase
      if (!reg_re)
         next_reg_rdata = reg_rdata;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state      <= fuse_pkg::st_boot;
         write_data <= `FUSE_RST_WORD;
         word_addr  <= `FUSE_RST_HALF;
         ctrl_lo    <= `FUSE_RST_BYTE;
         ctrl_hi    <= `FUSE_RST_BYTE;
         read_data  <= `FUSE_RST_WORD;
         boot_word  <= `FUSE_RST_WORD;
         rd_capture <= 1'b0;
         prog_mode  <= 1'b0;
         boot_done  <= 1'b0;
         reg_rdata  <= `FUSE_RST_BYTE;
      end else begin
         state      <= next_state;
         write_data <= next_write_data;
         word_addr  <= next_word_addr;
         ctrl_lo    <= next_ctrl_lo;
         ctrl_hi    <= next_ctrl_hi;
         read_data  <= next_read_data;
         boot_word  <= next_boot_word;
         rd_capture <= next_rd_capture;
         prog_mode  <= next_prog_mode;
         boot_done  <= next_boot_done;
         reg_rdata  <= next_reg_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   a_data_held: assert property (@(posedge clk) disable iff (sys_rst)
      !(reg_we && reg_addr < 4'h6) |=> ($stable(write_data) && $stable(word_addr)))
      else $error("data or address changed without a register write");

   a_margin_read: assert property (@(posedge clk) disable iff (sys_rst)
      (rd_capture && prog_mode) |=> (read_data == $past(rd_strong)))
      else $error("margin read returned weak bits");

   a_reset_normal: assert property (@(posedge clk)
      sys_rst |=> (!prog_mode && state == fuse_pkg::st_boot))
      else $error("reset left programming configuration active");

   a_read_launch: assert property (@(posedge clk) disable iff (sys_rst)
      read_go |=> rd_capture ##1 (read_data == $past(rd_word)))
      else $error("read sequence did not load read data");

   a_boot_load: assert property (@(posedge clk)
      $fell(sys_rst) |-> ##[1:3] boot_done)
      else $error("boot word not loaded after reset");

   a_burn_edge: assert property (@(posedge clk) disable iff (sys_rst)
      burn_go |=> (ctrl_lo[`FUSE_BIT_BURN] && !burn_go))
      else $error("burn strobe fired without level change");

   a_boot_port: assert property (@(posedge clk) disable iff (sys_rst)
      (reg_re && reg_addr == `FUSE_OFS_BOOT) |=> (reg_rdata == $past(boot_word[7:0])))
      else $error("boot word low byte misread");
endmodule : fuse_access
`default_nettype wire

// >>> tb/fuse_host_model.sv
// host model issuing byte register accesses and fuse sequences
`timescale 1ns/1ps
`default_nettype none
module fuse_host_model #(
   parameter int WAIT_CYCLES = 25000
) (
   input  wire logic       clk,
   output logic            reg_we,
   output logic            reg_re,
   output logic [3:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_we = 1'h0;
      reg_re = 1'h0;
      reg_addr = 4'hf;
      reg_wdata = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_we = 1'h1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #1;
      reg_we = 1'h0;
      // released lines must not keep the last value
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] q);
      @(posedge clk);
      #1;
      reg_re = 1'h1;
      reg_addr = a;
      @(posedge clk);
      #1;
      reg_re = 1'h0;
      reg_addr = ~a;
      q = reg_rdata;
   endtask : rd
   task automatic rd32(input logic [3:0] a, output logic [31:0] q);
      logic [7:0] b;
      for (int i = 0; i < 4; i++) begin
         rd(4'(a + i), b);
         q[8*i +: 8] = b;
      end
   endtask : rd32
   task automatic wr16(input logic [3:0] a, input logic [15:0] d);
      wr(a, d[7:0]);
      wr(4'(a + 1), d[15:8]);
   endtask : wr16
   // device does not enforce host waits; shortened in the bench
   task automatic hold();
      repeat (WAIT_CYCLES) @(posedge clk);
   endtask : hold
   ////////////////////////////////////////////////////////////////////////////////
   // stage write order
   task automatic stage(input logic [7:0] hi_a, input logic [15:0] d,
                        input logic [7:0] hi_b, input bit strobe);
      wr(4'h7, hi_a);
      wr16(4'h0, d);
      wr(4'h6, 8'h08);
      hold();
      wr(4'h7, hi_b);
      if (strobe) begin
         wr(4'h6, 8'h88);
         wr(4'h6, 8'h80);
         wr(4'h6, 8'h00);
      end
   endtask : stage
   // power byte of stage one lives outside this block
   task automatic configure();
      stage(8'h03, 16'h9220, 8'h02, 1'b1);
      stage(8'h05, 16'h000e, 8'h04, 1'b1);
      stage(8'h01, 16'h1024, 8'h00, 1'b0);
   endtask : configure
   task automatic load(input logic [15:0] adr, input logic [31:0] d);
      wr(4'h6, 8'h00);
      wr16(4'h0, d[15:0]);
      wr16(4'h2, d[31:16]);
      wr16(4'h4, adr);
   endtask : load
   task automatic burn();
      wr(4'h6, 8'h40);
      wr(4'h6, 8'h00);
      hold();
   endtask : burn
   task automatic read_word(input logic [15:0] adr, output logic [31:0] q);
      wr16(4'h4, adr);
      wr(4'h6, 8'h03);
      wr(4'h6, 8'h01);
      @(posedge clk);
      rd32(4'h8, q);
      wr(4'h6, 8'h00);
   endtask : read_word
endmodule : fuse_host_model
`default_nettype wire

// >>> tb/fuse_access_tb_top.sv
// testbench for the fuse access sequencer
`timescale 1ns/1ps
`default_nettype none
module fuse_access_tb_top;
   logic        clk;
   logic        sys_rst;
   logic        reg_we;
   logic        reg_re;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic        prog_mode;
   logic        boot_done;
   logic [31:0] word;
   int          bad_count;
   int          comparisons;
   fuse_access dut (.clk(clk), .sys_rst(sys_rst), .reg_we(reg_we), .reg_re(reg_re),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .prog_mode(prog_mode), .boot_done(boot_done));
   fuse_host_model #(.WAIT_CYCLES(50)) host (.clk(clk), .reg_we(reg_we), .reg_re(reg_re),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   always #20 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      if (bad_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict
   task automatic do_reset();
      @(posedge clk);
      #1;
      sys_rst = 1'h1;
      repeat (4) @(posedge clk);
      #1;
      sys_rst = 1'h0;
      repeat (2) @(posedge clk);
      #1;
      check(32'(boot_done), 32'h1);
      check(32'(prog_mode), 32'h0);
   endtask : do_reset
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_normal_read();
      host.rd32(4'h8, word);
      check(word, 32'h0);
      host.rd32(4'hc, word);
      check(word, 32'h0);
      // blank fuses read zero, so an all-ones word shows every burned bit
      host.load(16'h0005, 32'hffff_ffff);
      host.burn();
      host.read_word(16'h0005, word);
      check(word, 32'hffff_ffff);
      host.rd32(4'h4, word);
      check(word, 32'h0000_0005);
      host.wr16(4'h4, 16'h0400);
      host.wr(4'h6, 8'h01);
      repeat (3) @(posedge clk);
      host.rd32(4'h8, word);
      check(word, 32'hffff_ffff);
   endtask : t_normal_read
   task automatic t_program();
      host.configure();
      check(32'(prog_mode), 32'h1);
      host.load(16'h0400, 32'hffff_ffff);
      host.burn();
      // margin mode trusts only strong bits, so a single burn reads back blank
      host.read_word(16'h0400, word);
      check(word, 32'h0);
      host.burn();
      host.read_word(16'h0400, word);
      check(word, 32'hffff_ffff);
      host.rd32(4'h0, word);
      check(word, 32'hffff_ffff);
      do_reset();
      host.rd32(4'hc, word);
      check(word, 32'hffff_ffff);
      host.read_word(16'h0400, word);
      check(word, 32'hffff_ffff);
   endtask : t_program
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'h0;
      sys_rst = 1'h1;
      bad_count = 0;
      comparisons = 0;
      do_reset();
      t_normal_read();
      t_program();
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      give_verdict();
   end
endmodule : fuse_access_tb_top
`default_nettype wire
